// ==== rtl/linkage_params.svh ====
// constants for the call, return and interrupt linkage sequencer
`ifndef LINKAGE_PARAMS_SVH
`define LINKAGE_PARAMS_SVH
`define REG_STACK 3'h6
`define REG_PC 3'h7
`define WORD_STEP 16'h0002
`define EVEN_MASK 16'hfffe
`define VEC_LOW_MASK 16'h01fc
`define PSW_RESET 16'h0000
`define REG_RESET 16'h0000
`endif

// ==== rtl/linkage_pkg.sv ====
// types for the call, return and interrupt linkage sequencer
package linkage_pkg;
	typedef enum logic [2:0] {
		OP_JUMP_TO_SUBROUTINE,
		OP_RETURN_FROM_SUBROUTINE,
		OP_UNLINKED_JUMP,
		OP_ARG_AUTOINC,
		OP_RETURN_FROM_INTERRUPT
	} op_t;
	typedef enum logic [3:0] {
		S_IDLE,
		S_CALL_PUSH,
		S_RET_POP,
		S_ARG_READ,
		S_IRQ_PUSH_PSW,
		S_IRQ_PUSH_PC,
		S_IRQ_VEC_PC,
		S_IRQ_VEC_PSW,
		S_RTI_POP_PC,
		S_RTI_POP_PSW
	} state_t;
endpackage : linkage_pkg

// ==== rtl/stack_if.sv ====
// carrier between the sequencer and its stack pointer step unit
`timescale 1ns/100ps
interface stack_if;
	logic [15:0] sp;
	logic push;
	logic pop;
	logic [15:0] addr;
	logic [15:0] sp_next;
	modport user (output sp, output push, output pop, input addr, input sp_next);
	modport unit (input sp, input push, input pop, output addr, output sp_next);
endinterface : stack_if

// ==== rtl/stack_step.sv ====
// word stack pointer step: pre-decrement push, post-increment pop
`timescale 1ns/100ps
`include "linkage_params.svh"
module stack_step (
	stack_if.unit stk
);
	wire [15:0] sp_even = stk.sp & `EVEN_MASK; // see RQ14
	wire [15:0] sp_dec = sp_even - `WORD_STEP; // see RQ13
	wire [15:0] sp_inc = sp_even + `WORD_STEP; // see RQ15
	// pushes and pops always pair in reverse order, so nesting is free; see RQ12
	assign stk.addr = stk.push ? sp_dec : sp_even;
	assign stk.sp_next = stk.push ? sp_dec : (stk.pop ? sp_inc : sp_even);
endmodule : stack_step

// ==== rtl/call_return_interrupt_linkage.sv ====
// call, return and interrupt linkage sequencer with the general registers
// How it works
// RQ1: a subroutine call first pushes the named linkage register onto the hardware stack.
// RQ2: then the linkage register takes the current program counter and control goes to the entry.
// RQ3: an autoincrement argument read through the linkage register advances it to the next word.
// RQ4: a subroutine return copies the named register to the program counter, then pops it.
// RQ5: a return naming the program counter resumes at the address taken from the stack top.
// RQ6: a plain jump uses no linkage register and pushes nothing.
// RQ7: interrupt entry pushes the status word first and then the program counter.
// RQ8: after saving, a new program counter and status word are read from two vector words.
// RQ9: the first vector word is the service address and the second the new status word.
// RQ10: vectors lie in low memory, each device supplying its own fixed location.
// RQ11: interrupt return pops the program counter and then the status word.
// RQ12: calls and interrupts nest in any mixture since linkage pops in reverse push order.
// RQ13: the stack grows downward, push pre-decrements and pop post-increments the pointer.
// RQ14: the hardware stack pointer works in whole words and stays even.
// RQ15: each push or pop moves the pointer by two and interrupts are taken at boundaries.
// RQ16: the hardware stack pointer is register six and the program counter register seven.
`timescale 1ns/100ps
`include "linkage_params.svh"
module call_return_interrupt_linkage #(
	parameter int DATA_W = 16
) (
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RESETN,
	// command from instruction decode
	input wire logic CMD_VALID,
	input wire linkage_pkg::op_t CMD_OP,
	input wire logic [2:0] CMD_REG,
	input wire logic [15:0] CMD_TARGET,
	input wire logic INSN_BOUNDARY,
	// register load from the datapath
	input wire logic REG_WE,
	input wire logic [2:0] REG_SEL,
	input wire logic [15:0] REG_WDATA,
	input wire logic PSW_WE,
	input wire logic [15:0] PSW_WDATA,
	// interrupt request
	input wire logic IRQ_REQ,
	input wire logic [15:0] IRQ_VECTOR,
	output logic IRQ_ACK,
	// memory port
	output logic MEM_REQ,
	output logic MEM_WE,
	output logic [15:0] MEM_ADDR,
	output logic [15:0] MEM_WDATA,
	input wire logic [15:0] MEM_RDATA,
	input wire logic MEM_ACK,
	// state
	output logic BUSY,
	output logic DONE,
	output logic [15:0] ARG_DATA,
	output logic [15:0] PC,
	output logic [15:0] SP,
	output logic [15:0] PSW
);
	import linkage_pkg::*;

	if (DATA_W != 16) begin : g_check
		$error("only a 16-bit word is supported");
	end

	state_t state_q, state_d;
	logic [15:0] regs_q [8];
	logic [15:0] psw_q, vec_q, tgt_q, arg_q, addr_q, wdata_q;
	logic [2:0] sel_q;
	logic req_q, we_q, busy_q, done_q, irq_ack_q;
	stack_if stk ();

	stack_step u_stack_step (
		.stk(stk)
	);

	wire in_idle = (state_q == S_IDLE);
	wire irq_take = in_idle && IRQ_REQ && INSN_BOUNDARY; // see RQ15
	wire cmd_take = in_idle && CMD_VALID && !irq_take;
	wire jmp_take = cmd_take && (CMD_OP == OP_UNLINKED_JUMP);
	wire [2:0] sel_d = in_idle ? CMD_REG : sel_q;
	wire [15:0] sel_val = regs_q[sel_d];
	wire [15:0] cmd_reg_val = regs_q[CMD_REG];
	wire [15:0] link_val = regs_q[sel_q];
	wire [15:0] vec_d = IRQ_VECTOR & `VEC_LOW_MASK; // see RQ10
	wire launch = (state_d != S_IDLE) && (state_d != state_q);
	wire is_push = (state_d == S_CALL_PUSH) || (state_d == S_IRQ_PUSH_PSW) ||
		(state_d == S_IRQ_PUSH_PC);
	wire is_pop = (state_d == S_RET_POP) || (state_d == S_RTI_POP_PC) ||
		(state_d == S_RTI_POP_PSW);

	assign stk.sp = regs_q[`REG_STACK]; // see RQ16
	assign stk.push = launch && is_push;
	assign stk.pop = launch && is_pop;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			S_IDLE: begin
				if (irq_take) begin
					state_d = S_IRQ_PUSH_PSW; // see RQ7
				end else if (CMD_VALID) begin
					unique case (CMD_OP)
						OP_JUMP_TO_SUBROUTINE: state_d = S_CALL_PUSH; // see RQ1
						OP_RETURN_FROM_SUBROUTINE: state_d = S_RET_POP;
						OP_ARG_AUTOINC: state_d = S_ARG_READ;
						OP_RETURN_FROM_INTERRUPT: state_d = S_RTI_POP_PC;
						OP_UNLINKED_JUMP: state_d = S_IDLE; // see RQ6
					endcase
				end
			end
			S_IRQ_PUSH_PSW: if (MEM_ACK) state_d = S_IRQ_PUSH_PC;
			S_IRQ_PUSH_PC: if (MEM_ACK) state_d = S_IRQ_VEC_PC; // see RQ8
			S_IRQ_VEC_PC: if (MEM_ACK) state_d = S_IRQ_VEC_PSW;
			S_RTI_POP_PC: if (MEM_ACK) state_d = S_RTI_POP_PSW; // see RQ11
			S_CALL_PUSH, S_RET_POP, S_ARG_READ, S_IRQ_VEC_PSW, S_RTI_POP_PSW: begin
				if (MEM_ACK) state_d = S_IDLE;
			end
		endcase
	end

	logic [15:0] l_addr, l_wdata;
	always_comb begin
		l_addr = stk.addr;
		l_wdata = regs_q[`REG_PC];
		unique case (state_d)
			S_CALL_PUSH: l_wdata = sel_val; // see RQ1
			S_IRQ_PUSH_PSW: l_wdata = psw_q; // see RQ7
			S_ARG_READ: l_addr = sel_val & `EVEN_MASK;
			S_IRQ_VEC_PC: l_addr = vec_q;
			S_IRQ_VEC_PSW: l_addr = vec_q + `WORD_STEP;
			default: l_wdata = regs_q[`REG_PC];
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			state_q <= S_IDLE;
			req_q <= 1'b0;
			we_q <= 1'b0;
			addr_q <= 16'h0000;
			wdata_q <= 16'h0000;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			irq_ack_q <= 1'b0;
		end else begin
			state_q <= state_d;
			busy_q <= (state_d != S_IDLE);
			done_q <= jmp_take || (!in_idle && state_d == S_IDLE);
			irq_ack_q <= irq_take;
			if (launch) begin
				req_q <= 1'b1;
				we_q <= is_push;
				addr_q <= l_addr;
				wdata_q <= l_wdata;
			end else if (MEM_ACK) begin
				req_q <= 1'b0;
				we_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			for (int i = 0; i < 8; i++) begin
				regs_q[i] <= `REG_RESET;
			end
			psw_q <= `PSW_RESET;
			vec_q <= 16'h0000;
			tgt_q <= 16'h0000;
			arg_q <= 16'h0000;
			sel_q <= 3'h0;
		end else begin
			if (in_idle && REG_WE) regs_q[REG_SEL] <= REG_WDATA;
			if (in_idle && PSW_WE) psw_q <= PSW_WDATA;
			if (cmd_take) begin
				sel_q <= CMD_REG;
				tgt_q <= CMD_TARGET;
			end
			if (irq_take) vec_q <= vec_d;
			if (jmp_take) regs_q[`REG_PC] <= CMD_TARGET; // see RQ6
			if (launch && (is_push || is_pop)) regs_q[`REG_STACK] <= stk.sp_next; // see RQ13
			if (launch && state_d == S_RET_POP) regs_q[`REG_PC] <= sel_val; // see RQ4
			if (launch && state_d == S_ARG_READ) regs_q[sel_d] <= sel_val + `WORD_STEP; // see RQ3
			if (MEM_ACK) begin
				unique case (state_q)
					S_CALL_PUSH: begin
						regs_q[sel_q] <= regs_q[`REG_PC]; // see RQ2
						regs_q[`REG_PC] <= tgt_q; // see RQ2
					end
					S_RET_POP: regs_q[sel_q] <= MEM_RDATA; // see RQ5
					S_ARG_READ: arg_q <= MEM_RDATA;
					S_IRQ_VEC_PC: regs_q[`REG_PC] <= MEM_RDATA; // see RQ9
					S_IRQ_VEC_PSW: psw_q <= MEM_RDATA; // see RQ9
					S_RTI_POP_PC: regs_q[`REG_PC] <= MEM_RDATA; // see RQ11
					S_RTI_POP_PSW: psw_q <= MEM_RDATA; // see RQ11
					default: arg_q <= arg_q;
				endcase
			end
		end
	end

	assign MEM_REQ = req_q;
	assign MEM_WE = we_q;
	assign MEM_ADDR = addr_q;
	assign MEM_WDATA = wdata_q;
	assign BUSY = busy_q;
	assign DONE = done_q;
	assign IRQ_ACK = irq_ack_q;
	assign ARG_DATA = arg_q;
	assign PC = regs_q[`REG_PC];
	assign SP = regs_q[`REG_STACK];
	assign PSW = psw_q;

	a_call_push_link: assert property ( // see RQ1
		@(posedge CLK_SYS) disable iff (!RESETN)
		(cmd_take && CMD_OP == OP_JUMP_TO_SUBROUTINE) |=>
			MEM_REQ && MEM_WE && MEM_WDATA == $past(cmd_reg_val))
		else $error("call did not push the linkage register");
	a_call_pc_load: assert property ( // see RQ2
		@(posedge CLK_SYS) disable iff (!RESETN)
		(state_q == S_CALL_PUSH && MEM_ACK && sel_q != `REG_STACK) |=>
			PC == $past(tgt_q) && DONE && !BUSY)
		else $error("call did not jump to the entry");
	a_arg_advance: assert property ( // see RQ3
		@(posedge CLK_SYS) disable iff (!RESETN)
		(cmd_take && CMD_OP == OP_ARG_AUTOINC) |=>
			link_val == $past(cmd_reg_val) + 16'h0002)
		else $error("argument read did not advance the linkage register");
	a_ret_pc_copy: assert property ( // see RQ4
		@(posedge CLK_SYS) disable iff (!RESETN)
		(cmd_take && CMD_OP == OP_RETURN_FROM_SUBROUTINE) |=>
			PC == $past(cmd_reg_val) && MEM_REQ && !MEM_WE && MEM_ADDR == $past(SP))
		else $error("return did not copy the register and pop");
	a_jump_no_stack: assert property ( // see RQ6
		@(posedge CLK_SYS) disable iff (!RESETN)
		jmp_take |=> !MEM_REQ && SP == $past(SP) && PC == $past(CMD_TARGET))
		else $error("plain jump touched the stack");
	a_irq_psw_first: assert property ( // see RQ7
		@(posedge CLK_SYS) disable iff (!RESETN)
		irq_take |=> MEM_WE && MEM_WDATA == $past(PSW) && MEM_ADDR == $past(SP) - 16'h0002)
		else $error("interrupt entry did not push the status word first");
	a_vector_read: assert property ( // see RQ8
		@(posedge CLK_SYS) disable iff (!RESETN)
		(state_q == S_IRQ_VEC_PSW && MEM_REQ) |-> !MEM_WE && MEM_ADDR == vec_q + 16'h0002)
		else $error("second vector word read from the wrong place");
	a_rti_psw_pop: assert property ( // see RQ11
		@(posedge CLK_SYS) disable iff (!RESETN)
		(state_q == S_RTI_POP_PSW && MEM_ACK) |=> PSW == $past(MEM_RDATA) && !BUSY)
		else $error("interrupt return did not restore the status word");
	a_push_predec: assert property ( // see RQ13
		@(posedge CLK_SYS) disable iff (!RESETN)
		(MEM_REQ && MEM_WE) |-> MEM_ADDR == SP)
		else $error("push address is not the decremented pointer");
	a_sp_even: assert property ( // see RQ14
		@(posedge CLK_SYS) disable iff (!RESETN)
		(MEM_REQ && state_q != S_ARG_READ) |-> !MEM_ADDR[0])
		else $error("stack access at an odd address");
endmodule : call_return_interrupt_linkage

// ==== verif/linkage_memory.sv ====
// main memory model holding the hardware stack and the interrupt vectors
`timescale 1ns/100ps
module linkage_memory (
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// answer delay in cycles
	input wire logic [3:0] lat,
	// memory port
	input wire logic req,
	input wire logic we,
	input wire logic [15:0] addr,
	input wire logic [15:0] wdata,
	output logic [15:0] rdata,
	output logic ack
);
	logic [15:0] mem [0:32767];
	logic [3:0] wait_q;
	wire go = req && !ack && (wait_q >= lat);
	// word store; vectors sit at fixed low locations, read data scrambles when idle
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ack <= 1'b0;
			wait_q <= 4'h0;
			rdata <= 16'h0000;
		end else begin
			ack <= go;
			wait_q <= (go || ack || !req) ? 4'h0 : wait_q + 4'h1;
			rdata <= go ? mem[addr[15:1]] : ~rdata;
			if (go && we)
				mem[addr[15:1]] <= wdata;
		end
	end
endmodule : linkage_memory

// ==== verif/call_return_interrupt_linkage_bench.sv ====
// testbench for the call, return and interrupt linkage sequencer
`timescale 1ns/100ps
`include "linkage_params.svh"
module call_return_interrupt_linkage_bench;
	import linkage_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic cmd_valid = 1'b0;
	op_t cmd_op = OP_UNLINKED_JUMP;
	logic [2:0] cmd_reg = 3'h0;
	logic [15:0] cmd_target = 16'h0000;
	logic insn_boundary = 1'b1;
	logic reg_we = 1'b0;
	logic [2:0] reg_sel = 3'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic psw_we = 1'b0;
	logic [15:0] psw_wdata = 16'h0000;
	logic irq_req = 1'b0;
	logic [15:0] irq_vector = 16'h0000;
	logic [3:0] lat = 4'h3;
	logic irq_ack, mem_req, mem_we, mem_ack, busy, done;
	logic [15:0] mem_addr, mem_wdata, mem_rdata, arg_data, pc, sp, psw;
	int n_mismatch = 0;
	int checks = 0;
	int n_acc = 0;
	int n_irq = 0;
	int a;
	call_return_interrupt_linkage u_call_return_interrupt_linkage (
		.CLK_SYS(clk), .RESETN(resetn), .CMD_VALID(cmd_valid), .CMD_OP(cmd_op),
		.CMD_REG(cmd_reg), .CMD_TARGET(cmd_target), .INSN_BOUNDARY(insn_boundary),
		.REG_WE(reg_we), .REG_SEL(reg_sel), .REG_WDATA(reg_wdata), .PSW_WE(psw_we),
		.PSW_WDATA(psw_wdata), .IRQ_REQ(irq_req), .IRQ_VECTOR(irq_vector), .IRQ_ACK(irq_ack),
		.MEM_REQ(mem_req), .MEM_WE(mem_we), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata),
		.MEM_RDATA(mem_rdata), .MEM_ACK(mem_ack), .BUSY(busy), .DONE(done),
		.ARG_DATA(arg_data), .PC(pc), .SP(sp), .PSW(psw));
	linkage_memory u_linkage_memory (.clk_sys(clk), .resetn(resetn), .lat(lat), .req(mem_req),
		.we(mem_we), .addr(mem_addr), .wdata(mem_wdata), .rdata(mem_rdata), .ack(mem_ack));
	initial begin
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		if (mem_req && mem_ack)
			n_acc <= n_acc + 1;
		if (irq_ack)
			n_irq <= n_irq + 1;
	end
	function logic [15:0] m(input logic [15:0] addr);
		return u_linkage_memory.mem[addr[15:1]];
	endfunction : m
	task stop_test;
		if (n_mismatch == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : stop_test
	task chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task load(input logic to_psw, input logic [2:0] r, input logic [15:0] v);
		@(negedge clk);
		psw_we = to_psw;
		reg_we = !to_psw;
		reg_sel = r;
		reg_wdata = v;
		psw_wdata = v;
		@(negedge clk);
		psw_we = 1'b0;
		reg_we = 1'b0;
	endtask : load
	task wait_done;
		int n;
		n = 0;
		while (done !== 1'b1 && n < 60) begin
			@(negedge clk);
			n++;
		end
		chk({15'h0000, done}, 16'h0001);
	endtask : wait_done
	task run(input op_t op, input logic [2:0] r, input logic [15:0] t);
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd_op = op;
		cmd_reg = r;
		cmd_target = t;
		@(negedge clk);
		cmd_valid = 1'b0;
		wait_done();
	endtask : run
	task t_call;
		load(1'b0, `REG_STACK, 16'h1000);
		load(1'b0, `REG_PC, 16'h0200);
		load(1'b0, 3'h5, 16'h1234);
		load(1'b1, 3'h0, 16'h00e0);
		u_linkage_memory.mem[16'h0100] = 16'haaaa;
		u_linkage_memory.mem[16'h0101] = 16'hbbbb;
		a = n_acc;
		run(OP_JUMP_TO_SUBROUTINE, 3'h5, 16'h0400);
		chk(m(16'h0ffe), 16'h1234);
		chk(sp, 16'h0ffe);
		chk(pc, 16'h0400);
		chk(16'(n_acc - a), 16'h0001);
		run(OP_ARG_AUTOINC, 3'h5, 16'h0000);
		chk(arg_data, 16'haaaa);
		run(OP_ARG_AUTOINC, 3'h5, 16'h0000);
		chk(arg_data, 16'hbbbb);
	endtask : t_call
	task t_return;
		u_linkage_memory.mem[16'h091a] = 16'h5a5a;
		run(OP_RETURN_FROM_SUBROUTINE, 3'h5, 16'h0000);
		chk(pc, 16'h0204);
		chk(sp, 16'h1000);
		run(OP_ARG_AUTOINC, 3'h5, 16'h0000);
		chk(arg_data, 16'h5a5a);
	endtask : t_return
	task t_jumps;
		lat = 4'h0;
		run(OP_JUMP_TO_SUBROUTINE, `REG_PC, 16'h0600);
		chk(m(16'h0ffe), 16'h0204);
		a = n_acc;
		run(OP_UNLINKED_JUMP, 3'h5, 16'h0700);
		chk(pc, 16'h0700);
		chk(sp, 16'h0ffe);
		chk(16'(n_acc - a), 16'h0000);
	endtask : t_jumps
	task t_irq;
		u_linkage_memory.mem[16'h0020] = 16'h0800;
		u_linkage_memory.mem[16'h0021] = 16'h00a0;
		@(negedge clk);
		irq_vector = 16'h0040;
		irq_req = 1'b1;
		insn_boundary = 1'b0;
		repeat (3) @(negedge clk);
		chk({15'h0000, busy}, 16'h0000);
		insn_boundary = 1'b1;
		@(negedge clk);
		irq_req = 1'b0;
		wait_done();
		chk(m(16'h0ffc), 16'h00e0);
		chk(m(16'h0ffa), 16'h0700);
		chk(sp, 16'h0ffa);
		chk(pc, 16'h0800);
		chk(psw, 16'h00a0);
		chk(16'(n_irq), 16'h0001);
	endtask : t_irq
	task t_unwind;
		run(OP_RETURN_FROM_INTERRUPT, 3'h0, 16'h0000);
		chk(pc, 16'h0700);
		chk(psw, 16'h00e0);
		chk(sp, 16'h0ffe);
		run(OP_RETURN_FROM_SUBROUTINE, `REG_PC, 16'h0000);
		chk(pc, 16'h0204);
		chk(sp, 16'h1000);
	endtask : t_unwind
	task t_refuse;
		lat = 4'h3;
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd_op = OP_JUMP_TO_SUBROUTINE;
		cmd_reg = 3'h5;
		cmd_target = 16'h0900;
		@(negedge clk);
		cmd_op = OP_UNLINKED_JUMP;
		cmd_target = 16'h0a00;
		@(negedge clk);
		cmd_valid = 1'b0;
		wait_done();
		chk(pc, 16'h0900);
		chk(m(16'h0ffe), 16'h1236);
		chk(sp, 16'h0ffe);
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd_op = OP_UNLINKED_JUMP;
		cmd_target = 16'h0b00;
		irq_vector = 16'h0241;
		irq_req = 1'b1;
		@(negedge clk);
		cmd_valid = 1'b0;
		irq_req = 1'b0;
		wait_done();
		chk(pc, 16'h0800);
		chk(psw, 16'h00a0);
		chk(m(16'h0ffc), 16'h00e0);
		chk(m(16'h0ffa), 16'h0900);
		chk(sp, 16'h0ffa);
		chk(16'(n_irq), 16'h0002);
	endtask : t_refuse
	initial begin
		repeat (5000) @(posedge clk);
		n_mismatch++;
		stop_test();
	end
	initial begin
		repeat (10) @(negedge clk);
		resetn = 1'b1;
		chk(pc | sp | psw, 16'h0000);
		t_call();
		t_return();
		t_jumps();
		t_irq();
		t_unwind();
		t_refuse();
		stop_test();
	end
endmodule : call_return_interrupt_linkage_bench
